// ==== rtl/diagnostics_and_alarm_monitor.sv ====
// Purpose: Self-test, flash checksum, diagnostic flags and two alarms with a line indicator
// Assumes: sample_tick_i pulses once per internal sample period; flash reads return next cycle
// Notes: Register port is word wide with byte enables; read data valid the cycle after rd
`timescale 1ns/1ps
`include "diag_alarm_map.svh"
module diagnostics_and_alarm_monitor (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [6:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [1:0] reg_be_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Sample timing and sensor data
  input wire logic sample_tick_i,
  input wire diag_alarm_pkg::src_bank_t src_raw_i,
  input wire diag_alarm_pkg::src_bank_t src_filt_i,
  // Error conditions
  input wire logic supply_high_i,
  input wire logic supply_low_i,
  input wire logic overrange_i,
  input wire logic spi_fail_i,
  input wire logic flash_upd_fail_i,
  // Flash read port
  output logic [9:0] flash_addr_o,
  input wire logic [15:0] flash_data_i,
  // Self-test stimulus
  output logic stim_pos_o,
  output logic stim_neg_o,
  // General-purpose lines
  input wire logic data_ready_i,
  input wire logic [1:0] gpio_out_i,
  input wire logic [1:0] gpio_oe_i,
  output logic io_line_first_o,
  output logic io_line_first_oe_o,
  output logic io_line_second_o,
  output logic io_line_second_oe_o
);
  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  diag_alarm_pkg::word_t thr_one_q, thr_two_q, win_one_q, win_two_q, cfg_q, misc_q, misc_d;
  diag_alarm_pkg::word_t diag_q, diag_d, cond, set_v, clr_v;
  diag_alarm_pkg::src_bank_t bank;
  diag_alarm_pkg::st_state_e st_q;
  diag_alarm_pkg::mt_state_e mt_q;
  logic [7:0] st_cnt_q;
  logic [5:0][15:0] base_q;
  logic [5:0] st_fail_q, st_fail_d;
  logic st_err_q;
  logic [9:0] fl_addr_q;
  logic fl_valid_q;
  logic [15:0] sum_q;
  logic flash_fail_q;
  logic [1:0] line_q, oe_q, line_d, oe_d;
  logic [1:0] alarm_act;
  logic alarm_lvl, dr_lvl;
  logic wr_thr1, wr_thr2, wr_win1, wr_win2, wr_cfg, wr_misc, rd_diag;
  logic st_done, mt_done;
  alarm_if al1_if ();
  alarm_if al2_if ();

  // Even-address decode; odd byte address maps onto its word
  function automatic logic at(input logic [6:0] a, input logic [6:0] want);
    at = ({a[6:1], 1'b0} == want);
  endfunction

  // Byte-lane write merge, only writable bits change
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [15:0] mask, input logic [1:0] be);
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~lane) | (wd & lane);
  endfunction

  // Magnitude of a difference between two samples
  function automatic logic [15:0] mag_diff(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    d = a - b;
    mag_diff = d[15] ? (16'h0000 - d) : d;
  endfunction

  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  // Write strobes and the flag read strobe
  always_comb begin
    wr_thr1 = reg_wr_i && at(reg_addr_i, `ADDR_THR_ONE);
    wr_thr2 = reg_wr_i && at(reg_addr_i, `ADDR_THR_TWO);
    wr_win1 = reg_wr_i && at(reg_addr_i, `ADDR_WIN_ONE);
    wr_win2 = reg_wr_i && at(reg_addr_i, `ADDR_WIN_TWO);
    wr_cfg = reg_wr_i && at(reg_addr_i, `ADDR_ALM_CFG);
    wr_misc = reg_wr_i && at(reg_addr_i, `ADDR_MISC);
    rd_diag = reg_rd_i && at(reg_addr_i, `ADDR_DIAG);
  end

  // Alarm settings
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      thr_one_q <= `WORD_ZERO;
      thr_two_q <= `WORD_ZERO;
      win_one_q <= `WORD_ZERO;
      win_two_q <= `WORD_ZERO;
      cfg_q <= `WORD_ZERO;
    end else begin
      if (wr_thr1) thr_one_q <= merge(thr_one_q, reg_wdata_i, `THR_MASK, reg_be_i);
      if (wr_thr2) thr_two_q <= merge(thr_two_q, reg_wdata_i, `THR_MASK, reg_be_i);
      if (wr_win1) win_one_q <= merge(win_one_q, reg_wdata_i, `WIN_MASK, reg_be_i);
      if (wr_win2) win_two_q <= merge(win_two_q, reg_wdata_i, `WIN_MASK, reg_be_i);
      if (wr_cfg) cfg_q <= merge(cfg_q, reg_wdata_i, `CFG_MASK, reg_be_i);
    end
  end

  // Misc control; test bits hold while running so a stray write cannot abort
  always_comb begin
    misc_d = misc_q;
    if (wr_misc) misc_d = merge(misc_q, reg_wdata_i, `MISC_MASK, reg_be_i);
    if (st_q != diag_alarm_pkg::ST_IDLE) misc_d[`MISC_AUTOST] = 1'b1;
    if (mt_q != diag_alarm_pkg::MT_IDLE) misc_d[`MISC_MEMTEST] = 1'b1;
    if (st_done) misc_d[`MISC_AUTOST] = 1'b0;
    if (mt_done) misc_d[`MISC_MEMTEST] = 1'b0;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) misc_q <= `MISC_RESET;
    else misc_q <= misc_d;
  end

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= `WORD_ZERO;
    end else if (reg_rd_i) begin
      if (at(reg_addr_i, `ADDR_THR_ONE)) reg_rdata_o <= thr_one_q;
      else if (at(reg_addr_i, `ADDR_THR_TWO)) reg_rdata_o <= thr_two_q;
      else if (at(reg_addr_i, `ADDR_WIN_ONE)) reg_rdata_o <= win_one_q;
      else if (at(reg_addr_i, `ADDR_WIN_TWO)) reg_rdata_o <= win_two_q;
      else if (at(reg_addr_i, `ADDR_ALM_CFG)) reg_rdata_o <= cfg_q;
      else if (at(reg_addr_i, `ADDR_MISC)) reg_rdata_o <= misc_q;
      else if (rd_diag) reg_rdata_o <= diag_q;
      else reg_rdata_o <= `WORD_ZERO;
    end
  end

  // ---------------------------------------------------------------------------
  // Automatic self-test
  // ---------------------------------------------------------------------------
  assign st_done = (st_q == diag_alarm_pkg::ST_DONE);

  // Per-axis judgement against the response minimum
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      st_fail_d[i] = mag_diff(src_raw_i[i + `SRC_AXIS0], base_q[i]) <
                     ((i < 3) ? `ST_GYRO_MIN : `ST_ACCEL_MIN);
    end
  end

  // Baseline without stimulus, then stimulated response, each after settling
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_q <= diag_alarm_pkg::ST_IDLE;
      st_cnt_q <= 8'h00;
      base_q <= '0;
      st_fail_q <= 6'h00;
      st_err_q <= 1'b0;
    end else begin
      case (st_q)
        diag_alarm_pkg::ST_IDLE: begin
          st_cnt_q <= 8'h00;
          if (misc_q[`MISC_AUTOST]) st_q <= diag_alarm_pkg::ST_BASE;
        end
        diag_alarm_pkg::ST_BASE: begin
          if (sample_tick_i) begin
            st_cnt_q <= st_cnt_q + 8'h01;
            if (st_cnt_q == `ST_SETTLE - 8'h01) begin
              for (int i = 0; i < 6; i++) base_q[i] <= src_raw_i[i + `SRC_AXIS0];
              st_cnt_q <= 8'h00;
              st_q <= diag_alarm_pkg::ST_STIM;
            end
          end
        end
        diag_alarm_pkg::ST_STIM: begin
          if (sample_tick_i) begin
            st_cnt_q <= st_cnt_q + 8'h01;
            if (st_cnt_q == `ST_SETTLE - 8'h01) begin
              st_fail_q <= st_fail_d;
              st_err_q <= |st_fail_d;
              st_q <= diag_alarm_pkg::ST_DONE;
            end
          end
        end
        diag_alarm_pkg::ST_DONE: st_q <= diag_alarm_pkg::ST_IDLE;
        default: st_q <= diag_alarm_pkg::ST_IDLE;
      endcase
    end
  end

  // Stimulus pins; automatic test uses positive stimulus
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      stim_pos_o <= 1'b0;
      stim_neg_o <= 1'b0;
    end else begin
      stim_pos_o <= misc_q[`MISC_POS] || (st_q == diag_alarm_pkg::ST_STIM);
      stim_neg_o <= misc_q[`MISC_NEG];
    end
  end

  // ---------------------------------------------------------------------------
  // Flash checksum test: all words including the stored sum add to zero
  // ---------------------------------------------------------------------------
  assign mt_done = (mt_q == diag_alarm_pkg::MT_DONE);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mt_q <= diag_alarm_pkg::MT_IDLE;
      fl_addr_q <= 10'h000;
      fl_valid_q <= 1'b0;
      sum_q <= `WORD_ZERO;
      flash_fail_q <= 1'b0;
    end else begin
      fl_valid_q <= (mt_q == diag_alarm_pkg::MT_RUN);
      if (fl_valid_q) sum_q <= sum_q + flash_data_i;
      case (mt_q)
        diag_alarm_pkg::MT_IDLE: begin
          fl_addr_q <= 10'h000;
          sum_q <= `WORD_ZERO;
          if (misc_q[`MISC_MEMTEST]) mt_q <= diag_alarm_pkg::MT_RUN;
        end
        diag_alarm_pkg::MT_RUN: begin
          if (fl_addr_q == `FLASH_LAST) mt_q <= diag_alarm_pkg::MT_TAIL;
          else fl_addr_q <= fl_addr_q + 10'h001;
        end
        diag_alarm_pkg::MT_TAIL: mt_q <= diag_alarm_pkg::MT_DONE;
        diag_alarm_pkg::MT_DONE: begin
          flash_fail_q <= (sum_q != `WORD_ZERO);
          mt_q <= diag_alarm_pkg::MT_IDLE;
        end
        default: mt_q <= diag_alarm_pkg::MT_IDLE;
      endcase
    end
  end

  assign flash_addr_o = fl_addr_q;

  // ---------------------------------------------------------------------------
  // Diagnostic flags
  // ---------------------------------------------------------------------------
  // Standing conditions re-raise their flags each sample; set beats read clear
  always_comb begin
    cond = {st_fail_q, alarm_act, 1'b0, flash_fail_q, st_err_q, overrange_i,
            spi_fail_i, flash_upd_fail_i, 2'b00};
    set_v = sample_tick_i ? cond : `WORD_ZERO;
    clr_v = rd_diag ? `DIAG_RD_CLR : `WORD_ZERO;
    diag_d = (diag_q & ~clr_v) | set_v;
    // A finished test replaces its earlier outcome instead of adding to it
    if (st_done) begin
      diag_d[`DIAG_ST_FAIL] = st_fail_q;
      diag_d[`DIAG_ST_ERR] = st_err_q;
    end
    if (mt_done) diag_d[`DIAG_FLASH] = (sum_q != `WORD_ZERO);
    diag_d[1] = supply_high_i;
    diag_d[0] = supply_low_i;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) diag_q <= `WORD_ZERO;
    else diag_q <= diag_d;
  end

  // ---------------------------------------------------------------------------
  // Alarms
  // ---------------------------------------------------------------------------
  assign bank = cfg_q[`CFG_FILT] ? src_filt_i : src_raw_i;
  assign al1_if.sel = cfg_q[`CFG_A1_SRC];
  assign al1_if.rate = cfg_q[`CFG_A1_RATE];
  assign al1_if.thr = thr_one_q;
  assign al1_if.win = win_one_q[`WIN_DATA];
  assign al1_if.tick = sample_tick_i;
  assign al2_if.sel = cfg_q[`CFG_A2_SRC];
  assign al2_if.rate = cfg_q[`CFG_A2_RATE];
  assign al2_if.thr = thr_two_q;
  assign al2_if.win = win_two_q[`WIN_DATA];
  assign al2_if.tick = sample_tick_i;
  assign alarm_act = {al2_if.active, al1_if.active};

  alarm_eval u_alarm_one (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .cfg(al1_if.eval),
    .bank_i(bank)
  );

  alarm_eval u_alarm_two (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .cfg(al2_if.eval),
    .bank_i(bank)
  );

  // ---------------------------------------------------------------------------
  // Line arbitration
  // ---------------------------------------------------------------------------
  // Data ready claims first, alarm indicator next, plain pin setting last
  always_comb begin
    dr_lvl = misc_q[`MISC_DR_POL] ? data_ready_i : !data_ready_i;
    alarm_lvl = cfg_q[`CFG_OUT_POL] ? (|alarm_act) : !(|alarm_act);
    for (int k = 0; k < 2; k++) begin
      if (misc_q[`MISC_DR_EN] && (misc_q[`MISC_DR_SEL] == k[0])) begin
        line_d[k] = dr_lvl;
        oe_d[k] = 1'b1;
      end else if (cfg_q[`CFG_OUT_EN] && (cfg_q[`CFG_OUT_SEL] == k[0])) begin
        line_d[k] = alarm_lvl;
        oe_d[k] = 1'b1;
      end else begin
        line_d[k] = gpio_out_i[k];
        oe_d[k] = gpio_oe_i[k];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      line_q <= 2'b00;
      oe_q <= 2'b00;
    end else begin
      line_q <= line_d;
      oe_q <= oe_d;
    end
  end

  assign io_line_first_o = line_q[0];
  assign io_line_first_oe_o = oe_q[0];
  assign io_line_second_o = line_q[1];
  assign io_line_second_oe_o = oe_q[1];

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  chk_auto_clears: assert property (st_done |=> !misc_q[`MISC_AUTOST])
    else $error("self-test bit stayed set");
  chk_st_record: assert property (st_done |=> diag_q[`DIAG_ST_FAIL] == $past(st_fail_q))
    else $error("self-test result not recorded");
  chk_mem_result: assert property (mt_done |=> !misc_q[`MISC_MEMTEST] &&
      diag_q[`DIAG_FLASH] == ($past(sum_q) != `WORD_ZERO))
    else $error("memory test result or bit wrong");
  chk_read_clears: assert property (rd_diag && !sample_tick_i && !st_done && !mt_done
      |=> diag_q[15:2] == 14'h0000)
    else $error("flag read did not clear");
  chk_reassert: assert property (sample_tick_i && overrange_i |=> diag_q[`DIAG_OVR])
    else $error("standing overrange not re-raised");
  chk_supply_flags: assert property (##1 diag_q[1] == $past(supply_high_i) &&
      diag_q[0] == $past(supply_low_i))
    else $error("supply flags do not follow supply");
  chk_stim_manual: assert property (misc_q[`MISC_NEG] |=> stim_neg_o)
    else $error("negative stimulus missing");
  chk_dr_priority: assert property (misc_q[`MISC_DR_EN] && !misc_q[`MISC_DR_SEL]
      |=> io_line_first_oe_o && io_line_first_o == $past(dr_lvl))
    else $error("data ready lost line priority");
  chk_alarm_line: assert property (cfg_q[`CFG_OUT_EN] && cfg_q[`CFG_OUT_SEL] &&
      !(misc_q[`MISC_DR_EN] && misc_q[`MISC_DR_SEL])
      |=> io_line_second_oe_o && io_line_second_o == $past(alarm_lvl))
    else $error("alarm indicator level wrong");
  cov_self_test: cover property (st_q == diag_alarm_pkg::ST_STIM ##[1:100] st_done);
  cov_mem_test: cover property (mt_done);
  cov_read_reset: cover property (rd_diag ##1 sample_tick_i && overrange_i);
endmodule

// ==== rtl/diag_alarm_map.svh ====
// Purpose: Offsets, field positions, reset values and counts of the diagnostics block
// Assumes: Register port carries 16-bit words at even byte addresses
// Notes: Definitions only
`ifndef DIAG_ALARM_MAP_SVH
`define DIAG_ALARM_MAP_SVH
// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define ADDR_THR_ONE 7'h26
`define ADDR_THR_TWO 7'h28
`define ADDR_WIN_ONE 7'h2A
`define ADDR_WIN_TWO 7'h2C
`define ADDR_ALM_CFG 7'h2E
`define ADDR_MISC 7'h34
`define ADDR_DIAG 7'h3C
// ---------------------------------------------------------------------------
// Writable masks and reset values
// ---------------------------------------------------------------------------
`define THR_MASK 16'hBFFF
`define WIN_MASK 16'h00FF
`define CFG_MASK 16'hFFD7
`define MISC_MASK 16'h0FC7
`define WORD_ZERO 16'h0000
`define MISC_RESET 16'h0006
`define DIAG_RD_CLR 16'hFFFC
// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define MISC_MEMTEST 11
`define MISC_AUTOST 10
`define MISC_NEG 9
`define MISC_POS 8
`define MISC_DR_EN 2
`define MISC_DR_POL 1
`define MISC_DR_SEL 0
`define CFG_A2_SRC 15:12
`define CFG_A1_SRC 11:8
`define CFG_A2_RATE 7
`define CFG_A1_RATE 6
`define CFG_FILT 4
`define CFG_OUT_EN 2
`define CFG_OUT_POL 1
`define CFG_OUT_SEL 0
`define THR_DIR 15
`define THR_DATA 13:0
`define THR_SIGN 13
`define WIN_DATA 7:0
`define DIAG_ST_FAIL 15:10
`define DIAG_ALARM 9:8
`define DIAG_FLASH 6
`define DIAG_ST_ERR 5
`define DIAG_OVR 4
// ---------------------------------------------------------------------------
// Sources, counts and limits
// ---------------------------------------------------------------------------
`define SRC_NONE 4'h0
`define SRC_LAST 4'hB
`define SRC_AXIS0 2
`define ST_SETTLE 8'h10
`define ST_GYRO_MIN 16'h0100
`define ST_ACCEL_MIN 16'h0100
`define FLASH_LAST 10'h3FF
`endif

// ==== rtl/diag_alarm_pkg.sv ====
// Purpose: Types shared by the diagnostics block and its alarm evaluators
// Assumes: Nothing beyond the map header
// Notes: Source bank index equals the 4-bit source code
package diag_alarm_pkg;
  typedef logic [15:0] word_t;
  typedef logic [11:0][15:0] src_bank_t;
  typedef enum logic [1:0] {ST_IDLE, ST_BASE, ST_STIM, ST_DONE} st_state_e;
  typedef enum logic [1:0] {MT_IDLE, MT_RUN, MT_TAIL, MT_DONE} mt_state_e;
endpackage

// ==== rtl/alarm_if.sv ====
// Purpose: Settings and result of one alarm evaluator
// Assumes: Driven by the diagnostics top
// Notes: One instance per alarm
`timescale 1ns/1ps
interface alarm_if;
  logic [3:0] sel;
  logic rate;
  logic [15:0] thr;
  logic [7:0] win;
  logic tick;
  logic active;
  modport eval (input sel, input rate, input thr, input win, input tick, output active);
  modport ctrl (output sel, output rate, output thr, output win, output tick, input active);
endinterface

// ==== rtl/alarm_eval.sv ====
// Purpose: One alarm condition, static level or rate of change
// Assumes: tick pulses once per internal sample period
// Notes: Source data is 14-bit two's complement in the low bits
`timescale 1ns/1ps
`include "diag_alarm_map.svh"
module alarm_eval (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Settings and result
  alarm_if.eval cfg,
  // Selected sample bank
  input wire diag_alarm_pkg::src_bank_t bank_i
);
  logic signed [15:0] cur;
  logic signed [15:0] thr_s;
  logic signed [15:0] ref_q;
  logic [7:0] cnt_q;
  logic act_q;
  logic src_ok;
  logic lvl_hit;

  // Threshold test in the chosen direction
  function automatic logic hit(input logic signed [15:0] v, input logic signed [15:0] t,
                               input logic gt);
    hit = gt ? (v > t) : (v < t);
  endfunction

  // Zero and one both mean a single sample
  function automatic logic [7:0] eff_count(input logic [7:0] n);
    eff_count = (n == 8'h00) ? 8'h01 : n;
  endfunction

  // Source pick and sign extension
  always_comb begin
    src_ok = (cfg.sel != `SRC_NONE) && (cfg.sel <= `SRC_LAST);
    cur = src_ok ? {{2{bank_i[cfg.sel][`THR_SIGN]}}, bank_i[cfg.sel][`THR_DATA]} : 16'sh0000;
    thr_s = {{2{cfg.thr[`THR_SIGN]}}, cfg.thr[`THR_DATA]};
    lvl_hit = hit(cur, thr_s, cfg.thr[`THR_DIR]);
  end

  // Evaluation once per sample; window counted in samples, so period tracks sample rate
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      act_q <= 1'b0;
      cnt_q <= 8'h00;
      ref_q <= 16'sh0000;
    end else if (cfg.tick) begin
      if (!src_ok) begin
        act_q <= 1'b0;
        cnt_q <= 8'h00;
      end else if (!cfg.rate) begin
        act_q <= hit(cur, thr_s, cfg.thr[`THR_DIR]);
        cnt_q <= 8'h00;
      end else if (cnt_q + 8'h01 >= eff_count(cfg.win)) begin
        act_q <= hit(16'(cur - ref_q), thr_s, cfg.thr[`THR_DIR]);
        ref_q <= cur;
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign cfg.active = act_q;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  chk_disabled_quiet: assert property (cfg.tick && cfg.sel == `SRC_NONE |=> !cfg.active)
    else $error("disabled alarm became active");
  chk_static_level: assert property (cfg.tick && !cfg.rate && src_ok
      |=> cfg.active == $past(lvl_hit))
    else $error("static alarm result wrong");
  chk_window_one: assert property (cfg.tick && cfg.rate && src_ok && cfg.win <= 8'h01
      |=> cnt_q == 8'h00)
    else $error("short window did not evaluate each sample");
  cov_rate_fire: cover property (cfg.tick && cfg.rate ##1 cfg.active);
endmodule

// ==== tb/flash_model.sv ====
// Purpose: Flash array read by the checksum walk
// Assumes: Word for an address returns the next cycle
// Notes: Image sums to zero, so the check passes
`timescale 1ns/1ps
module flash_model (
  // Clock
  input wire logic clk_i,
  // Read port
  input wire logic [9:0] addr_i,
  output logic [15:0] data_o
);
  // Two nonzero words cancel in the 16-bit sum
  always_ff @(posedge clk_i) begin
    data_o <= (addr_i == 10'h001) ? 16'h1234 : (addr_i == 10'h002) ? 16'hEDCC : 16'h0000;
  end
endmodule

// ==== tb/test_diagnostics_and_alarm_monitor.sv ====
// Purpose: Self-checking bench for the diagnostics block
// Assumes: Inputs change at falling edges
// Notes: Byte enables tied high, four unused inputs tied low
`timescale 1ns/1ps
`include "diag_alarm_map.svh"
module test_diagnostics_and_alarm_monitor;
  logic core_clk_i = 0, reset_i = 1, wr = 0, rd = 0, tick = 0;
  logic sup_hi = 0, sup_lo = 0, ovr = 0, spi = 0, l1, l1_oe, l2, l2_oe, s_pos, s_neg;
  logic [6:0] addr = 7'h00;
  logic [15:0] wdata = 16'h0000, rdata, fdata, d;
  logic [9:0] faddr;
  diag_alarm_pkg::src_bank_t raw = '0;
  diag_alarm_pkg::src_bank_t filt = '0;
  int mismatches = 0, tests_run = 0;
  initial forever #2.5 core_clk_i = ~core_clk_i;
  flash_model fm (.clk_i(core_clk_i), .addr_i(faddr), .data_o(fdata));
  diagnostics_and_alarm_monitor dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_be_i(2'h3), .reg_wdata_i(wdata), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .sample_tick_i(tick), .src_raw_i(raw), .src_filt_i(filt),
    .supply_high_i(sup_hi), .supply_low_i(sup_lo), .overrange_i(ovr), .spi_fail_i(spi),
    .flash_upd_fail_i(1'b0), .flash_addr_o(faddr), .flash_data_i(fdata),
    .stim_pos_o(s_pos), .stim_neg_o(s_neg), .data_ready_i(1'b0), .gpio_out_i(2'h0),
    .gpio_oe_i(2'h0), .io_line_first_o(l1), .io_line_first_oe_o(l1_oe),
    .io_line_second_o(l2), .io_line_second_oe_o(l2_oe));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Strobes held one full cycle, released at the next falling edge
  task automatic wr_reg(input logic [6:0] a, input logic [15:0] v);
    @(negedge core_clk_i);
    addr = a;
    wdata = v;
    wr = 1;
    @(negedge core_clk_i);
    wr = 0;
  endtask
  task automatic rd_reg(input logic [6:0] a);
    @(negedge core_clk_i);
    addr = a;
    rd = 1;
    @(negedge core_clk_i);
    rd = 0;
    d = rdata;
  endtask
  // Tick, then room for the alarm and line registers
  task automatic pulse;
    @(negedge core_clk_i);
    tick = 1;
    @(negedge core_clk_i);
    tick = 0;
    repeat (3) @(negedge core_clk_i);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    wr_reg(`ADDR_THR_ONE, 16'hFFFF);
    rd_reg(`ADDR_THR_ONE);
    chk(d, `THR_MASK);
    wr_reg(`ADDR_WIN_ONE, 16'hFFFF);
    rd_reg(`ADDR_WIN_ONE);
    chk(d, `WIN_MASK);
    rd_reg(7'h40);
    chk(d, 16'h0000);
    chk({14'h0, l1_oe, l1}, 16'h0002);
    wr_reg(`ADDR_MISC, 16'h0206);
    @(negedge core_clk_i);
    chk({14'h0, s_neg, s_pos}, 16'h0002);
    wr_reg(`ADDR_MISC, 16'h0106);
    @(negedge core_clk_i);
    chk({14'h0, s_neg, s_pos}, 16'h0001);
    wr_reg(`ADDR_MISC, 16'h0006);
  endtask
  // Persisting error must survive a read only through the next tick
  task automatic t_flags;
    sup_hi = 1;
    ovr = 1;
    spi = 1;
    pulse();
    rd_reg(`ADDR_DIAG);
    chk(d, 16'h001A);
    rd_reg(`ADDR_DIAG);
    chk(d, 16'h0002);
    pulse();
    rd_reg(`ADDR_DIAG);
    chk(d, 16'h001A);
    ovr = 0;
    spi = 0;
    sup_hi = 0;
    sup_lo = 1;
    repeat (2) @(negedge core_clk_i);
    rd_reg(`ADDR_DIAG);
    chk(d, 16'h0001);
    sup_lo = 0;
    repeat (2) @(negedge core_clk_i);
  endtask
  task automatic t_memtest;
    wr_reg(`ADDR_MISC, 16'h0806);
    for (int i = 0; i <= 1200; i++) begin
      rd_reg(`ADDR_MISC);
      if (d[11] === 1'b0) break;
      if (i == 1200) begin
        mismatches++;
        end_sim();
      end
    end
    chk(d, 16'h0006);
    rd_reg(`ADDR_DIAG);
    chk(d, 16'h0000);
  endtask
  // Alarm one, accel x, static greater than, on the second line
  task automatic t_alarm;
    raw[5] = 16'h0200;
    wr_reg(`ADDR_THR_ONE, 16'h8100);
    wr_reg(`ADDR_ALM_CFG, 16'h0507);
    pulse();
    chk({14'h0, l2_oe, l2}, 16'h0003);
    pulse();
    rd_reg(`ADDR_DIAG);
    chk(d, 16'h0100);
    raw[5] = 16'h0050;
    pulse();
    chk({14'h0, l2_oe, l2}, 16'h0002);
    wr_reg(`ADDR_ALM_CFG, 16'h0505);
    repeat (2) @(negedge core_clk_i);
    chk({14'h0, l2_oe, l2}, 16'h0003);
  endtask
  // Alarm one, rate of change on filtered data; raw data stays flat
  task automatic t_rate;
    filt[5] = 16'h0300;
    wr_reg(`ADDR_WIN_ONE, 16'h0002);
    wr_reg(`ADDR_ALM_CFG, 16'h0557);
    repeat (2) pulse();
    chk({14'h0, l2_oe, l2}, 16'h0003);
    repeat (2) pulse();
    chk({14'h0, l2_oe, l2}, 16'h0002);
    filt[5] = 16'h0500;
    pulse();
    chk({14'h0, l2_oe, l2}, 16'h0002);
    pulse();
    chk({14'h0, l2_oe, l2}, 16'h0003);
    wr_reg(`ADDR_WIN_ONE, 16'h0000);
    pulse();
    chk({14'h0, l2_oe, l2}, 16'h0002);
  endtask
  // Automatic self-test: gyros answer the stimulus, accelerometers do not
  task automatic t_selftest;
    raw = '0;
    wr_reg(`ADDR_ALM_CFG, 16'h0000);
    pulse();
    rd_reg(`ADDR_DIAG);
    wr_reg(`ADDR_MISC, 16'h0406);
    for (int i = 0; i <= 40; i++) begin
      pulse();
      if (s_pos === 1'b1) break;
      if (i == 40) begin
        mismatches++;
        end_sim();
      end
    end
    raw[2] = 16'h0200;
    raw[3] = 16'h0200;
    raw[4] = 16'h0200;
    for (int i = 0; i <= 40; i++) begin
      pulse();
      rd_reg(`ADDR_MISC);
      if (d[10] === 1'b0) break;
      if (i == 40) begin
        mismatches++;
        end_sim();
      end
    end
    chk(d, 16'h0006);
    rd_reg(`ADDR_DIAG);
    chk(d, 16'hE020);
  endtask
  initial begin
    repeat (10) @(negedge core_clk_i);
    reset_i = 0;
    t_regs();
    t_flags();
    t_memtest();
    t_alarm();
    t_rate();
    t_selftest();
    end_sim();
  end
endmodule
